// >>> e3oh_pkg.sv
// Shared constants and types for the E3 G.832 overhead byte block.
package e3oh_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Frame geometry
  localparam int unsigned E3OH_FRAME_OCTETS = 537;
  localparam logic [9:0]  E3OH_LAST_IDX     = 10'h218;   // 536
  localparam logic [9:0]  E3OH_IDX_FA1      = 10'h000;
  localparam logic [9:0]  E3OH_IDX_FA2      = 10'h001;
  localparam logic [9:0]  E3OH_IDX_EM       = 10'h03c;   // Row 1, column 0
  localparam logic [9:0]  E3OH_IDX_TR       = 10'h078;   // Row 2
  localparam logic [9:0]  E3OH_IDX_MA       = 10'h0b4;   // Row 3
  localparam logic [9:0]  E3OH_IDX_NR       = 10'h0f0;   // Row 4
  localparam logic [9:0]  E3OH_IDX_GC       = 10'h12c;   // Row 5

  // Frame alignment patterns
  localparam logic [7:0]  E3OH_FA1_VAL      = 8'hf6;
  localparam logic [7:0]  E3OH_FA2_VAL      = 8'h28;

  ////////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0]  E3OH_ADDR_RX_NR   = 8'h1a;
  localparam logic [7:0]  E3OH_ADDR_RX_GC   = 8'h1b;
  localparam logic [7:0]  E3OH_ADDR_TX_GC   = 8'h35;
  localparam logic [7:0]  E3OH_ADDR_TX_NR   = 8'h37;
  localparam logic [7:0]  E3OH_ADDR_CTRL    = 8'h38;
  localparam logic [7:0]  E3OH_ADDR_STATUS  = 8'h39;
  localparam logic [7:0]  E3OH_ADDR_RX_MA   = 8'h3a;

  // Reset values
  localparam logic [7:0]  E3OH_RST_BYTE     = 8'h00;
  localparam logic [9:0]  E3OH_RST_IDX      = 10'h000;

  ////////////////////////////////////////////////////////////////////////////
  // Payload type codes
  localparam logic [2:0]  E3OH_PT_UNEQUIPPED = 3'h0;
  localparam logic [2:0]  E3OH_PT_EQUIPPED   = 3'h1;
  localparam logic [2:0]  E3OH_PT_ATM        = 3'h2;
  localparam logic [2:0]  E3OH_PT_TU12       = 3'h3;

  // Payload dependent field, undefined so sent as zero
  localparam logic [1:0]  E3OH_PDEP_VAL      = 2'h0;

  // Maintenance and adaptation byte layout, bit 7 first
  typedef struct packed {
    logic       ferf;
    logic       febe;
    logic [2:0] ptype;
    logic [1:0] pdep;
    logic       tmark;
  } e3oh_ma_type;

  // Control register layout, high bits first in the word
  typedef struct packed {
    logic [1:0] spare;
    logic       tmark;
    logic [2:0] ptype;
    logic       lapd_gc;
    logic       lapd_en;
  } e3oh_ctrl_type;

  localparam logic [7:0]  E3OH_RST_CTRL      = 8'h00;

endpackage : e3oh_pkg

// >>> e3oh_overhead.sv
// Overhead byte logic and payload FIFO of the E3 G.832 framer.
//
// Notes on behaviour
// - MA byte: FERF, FEBE, type, dependent, marker.
// - Receive LOS, OOF or AIS sets FERF.
// - FERF stays one while the problem lasts.
// - No receive problem sends FERF zero.
// - Receive parity mismatch sends FEBE one.
// - Matching received parity sends FEBE zero.
// - Payload type codes: unequipped, equipped, ATM, TU-12.
// - Timing marker zero only when PRC-traceable.
// - NR or GC byte selectable as LAPD carrier.
// - NR byte filled from transmit register otherwise.
// - Received NR byte copied to readable register.
// - GC byte filled from transmit register otherwise.
// - Received GC byte copied to readable register.
// - Receive BIP-8 over frame checked next frame.
// - Transmit BIP-8 placed in next frame's EM.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Synchronous FIFO, flip-flop storage, registered full flag, empty decoded from the count
module e3oh_fifo
  import e3oh_pkg::*;
#(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_b,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_C = AW'(DEPTH - 1) + {{AW{1'b0}}, 1'b1};

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      count_q;
  logic [AW:0]      count_d;
  logic             room_q;
  logic             push;
  logic             pop;

  // Handshakes on both sides
  assign push      = in_valid && room_q;
  assign pop       = out_ready && (count_q != '0);
  assign in_ready  = room_q;
  assign out_valid = (count_q != '0);
  assign out_data  = mem_q[rd_ptr_q];

  // Occupancy, simultaneous push and pop keep it steady
  always_comb begin
    count_d = count_q;
    if (push && !pop) begin
      count_d = count_q + {{AW{1'b0}}, 1'b1};
    end else if (pop && !push) begin
      count_d = count_q - {{AW{1'b0}}, 1'b1};
    end
  end

  // Pointers and count
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
      room_q   <= 1'b1;
    end else begin
      count_q <= count_d;
      room_q  <= (count_d != DEPTH_C);
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + AW'(1);
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + AW'(1);
      end
    end
  end

  // Storage has no reset, data is qualified by the count
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

endmodule : e3oh_fifo

////////////////////////////////////////////////////////////////////////////////
// Top: overhead insertion, overhead capture, register slave
module e3oh_overhead
  import e3oh_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = 32
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  // Register port
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic [7:0]      reg_rdata,
  // Payload bytes from the terminal side
  input  wire logic       pay_valid,
  output logic            pay_ready,
  input  wire logic [7:0] pay_data,
  // Transmit byte stream
  input  wire logic       tx_byte_en,
  input  wire logic [7:0] tx_trail_byte,
  output logic [7:0]      tx_byte,
  output logic            tx_byte_valid,
  output logic            tx_frame_end,
  // Transmit LAPD octet source
  input  wire logic [7:0] lapd_tx_byte,
  output logic            lapd_tx_take,
  // Receive byte stream, aligned by the receive framer
  input  wire logic       rx_byte_en,
  input  wire logic       rx_frame_start,
  input  wire logic [7:0] rx_byte,
  input  wire logic       rx_los,
  input  wire logic       rx_oof,
  input  wire logic       rx_ais,
  // Receive LAPD octet sink
  output logic [7:0]      lapd_rx_byte,
  output logic            lapd_rx_valid,
  // Frame parity result
  output logic            rx_bip_err
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  e3oh_ctrl_type ctrl_q;
  logic [7:0]    tx_nr_q;
  logic [7:0]    tx_gc_q;
  logic [7:0]    rx_nr_q;
  logic [7:0]    rx_gc_q;
  logic [7:0]    rx_ma_q;
  logic [7:0]    rdata_d;

  logic [9:0]    tx_idx_q;
  logic [7:0]    tx_bip_acc_q;
  logic [7:0]    tx_bip_prev_q;
  logic [7:0]    tx_byte_d;
  logic          tx_is_oh;
  logic          tx_is_ma;
  logic          tx_last;
  e3oh_ma_type   ma_d;
  logic          rx_problem;
  logic          febe_pend_q;

  logic [9:0]    rx_idx_q;
  logic [9:0]    rx_idx_cur;
  logic [7:0]    rx_bip_acc_q;
  logic [7:0]    rx_bip_prev_q;
  logic          rx_bip_ok_q;
  logic          rx_em_hit;
  logic          rx_mismatch;

  logic          fifo_valid;
  logic [7:0]    fifo_data;
  logic          fifo_pop;

  ////////////////////////////////////////////////////////////////////////////
  // Payload FIFO; it fills whenever overhead bytes hold off the drain
  e3oh_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst_b     (rst_b),
    .in_valid  (pay_valid),
    .in_ready  (pay_ready),
    .in_data   (pay_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Transmit frame position decode
  always_comb begin
    tx_is_oh = 1'b0;
    case (tx_idx_q)
      E3OH_IDX_FA1, E3OH_IDX_FA2, E3OH_IDX_EM, E3OH_IDX_TR,
      E3OH_IDX_MA, E3OH_IDX_NR, E3OH_IDX_GC: tx_is_oh = 1'b1;
      default:                               tx_is_oh = 1'b0;
    endcase
  end

  assign tx_is_ma = (tx_idx_q == E3OH_IDX_MA);
  assign tx_last  = (tx_idx_q == E3OH_LAST_IDX);
  // Payload leaves the FIFO only in payload slots; empty slots send zero
  assign fifo_pop = tx_byte_en && !tx_is_oh && fifo_valid;

  // Any receive problem drives FERF for the whole time it lasts
  assign rx_problem = rx_los || rx_oof || rx_ais;

  // MA byte assembly
  always_comb begin
    ma_d       = '0;
    ma_d.ferf  = rx_problem;
    ma_d.febe  = febe_pend_q;
    ma_d.ptype = ctrl_q.ptype;
    ma_d.pdep  = E3OH_PDEP_VAL;
    ma_d.tmark = ctrl_q.tmark;
  end

  // Outbound byte selection per slot
  always_comb begin
    tx_byte_d = fifo_valid ? fifo_data : E3OH_RST_BYTE;
    case (tx_idx_q)
      E3OH_IDX_FA1: tx_byte_d = E3OH_FA1_VAL;
      E3OH_IDX_FA2: tx_byte_d = E3OH_FA2_VAL;
      E3OH_IDX_EM:  tx_byte_d = tx_bip_prev_q;
      E3OH_IDX_TR:  tx_byte_d = tx_trail_byte;
      E3OH_IDX_MA:  tx_byte_d = ma_d;
      E3OH_IDX_NR: begin
        // LAPD takes the byte only when it is the selected carrier
        if (ctrl_q.lapd_en && !ctrl_q.lapd_gc) begin
          tx_byte_d = lapd_tx_byte;
        end else begin
          tx_byte_d = tx_nr_q;
        end
      end
      E3OH_IDX_GC: begin
        if (ctrl_q.lapd_en && ctrl_q.lapd_gc) begin
          tx_byte_d = lapd_tx_byte;
        end else begin
          tx_byte_d = tx_gc_q;
        end
      end
      default: tx_byte_d = fifo_valid ? fifo_data : E3OH_RST_BYTE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit byte counter, one step per byte strobe
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      tx_idx_q <= E3OH_RST_IDX;
    end else if (tx_byte_en) begin
      tx_idx_q <= tx_last ? E3OH_RST_IDX : tx_idx_q + 10'h001;
    end
  end

  // Transmit output registers
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      tx_byte       <= E3OH_RST_BYTE;
      tx_byte_valid <= 1'b0;
      tx_frame_end  <= 1'b0;
      lapd_tx_take  <= 1'b0;
    end else begin
      tx_byte_valid <= tx_byte_en;
      tx_frame_end  <= tx_byte_en && tx_last;
      // One LAPD octet per frame, taken in the carrier slot
      lapd_tx_take  <= tx_byte_en && ctrl_q.lapd_en &&
                       (tx_idx_q == (ctrl_q.lapd_gc ? E3OH_IDX_GC : E3OH_IDX_NR));
      if (tx_byte_en) begin
        tx_byte <= tx_byte_d;
      end
    end
  end

  // Transmit BIP-8 over every octet sent, frozen at frame end
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      tx_bip_acc_q  <= E3OH_RST_BYTE;
      tx_bip_prev_q <= E3OH_RST_BYTE;
    end else if (tx_byte_en) begin
      if (tx_last) begin
        tx_bip_prev_q <= tx_bip_acc_q ^ tx_byte_d;
        tx_bip_acc_q  <= E3OH_RST_BYTE;
      end else begin
        tx_bip_acc_q  <= tx_bip_acc_q ^ tx_byte_d;
      end
    end
  end

  // FEBE pending flag; a new mismatch wins over the MA-slot clear
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      febe_pend_q <= 1'b0;
    end else if (rx_mismatch) begin
      febe_pend_q <= 1'b1;
    end else if (tx_byte_en && tx_is_ma) begin
      febe_pend_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive position; frame start forces index zero for realignment
  assign rx_idx_cur  = rx_frame_start ? E3OH_RST_IDX : rx_idx_q;
  assign rx_em_hit   = rx_byte_en && (rx_idx_cur == E3OH_IDX_EM) && rx_bip_ok_q;
  assign rx_mismatch = rx_em_hit && (rx_byte != rx_bip_prev_q);

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rx_idx_q <= E3OH_RST_IDX;
    end else if (rx_byte_en) begin
      rx_idx_q <= (rx_idx_cur == E3OH_LAST_IDX) ? E3OH_RST_IDX
                                                 : rx_idx_cur + 10'h001;
    end
  end

  // Receive BIP-8; the first frame after reset has nothing to check
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rx_bip_acc_q  <= E3OH_RST_BYTE;
      rx_bip_prev_q <= E3OH_RST_BYTE;
      rx_bip_ok_q   <= 1'b0;
    end else if (rx_byte_en) begin
      if (rx_idx_cur == E3OH_LAST_IDX) begin
        rx_bip_prev_q <= rx_bip_acc_q ^ rx_byte;
        rx_bip_acc_q  <= E3OH_RST_BYTE;
        rx_bip_ok_q   <= 1'b1;
      end else if (rx_idx_cur == E3OH_RST_IDX) begin
        rx_bip_acc_q  <= rx_byte;
      end else begin
        rx_bip_acc_q  <= rx_bip_acc_q ^ rx_byte;
      end
    end
  end

  // Parity error pulse toward performance monitoring
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rx_bip_err <= 1'b0;
    end else begin
      rx_bip_err <= rx_mismatch;
    end
  end

  // Received overhead capture; always updated, LAPD or not
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rx_nr_q <= E3OH_RST_BYTE;
      rx_gc_q <= E3OH_RST_BYTE;
      rx_ma_q <= E3OH_RST_BYTE;
    end else if (rx_byte_en) begin
      if (rx_idx_cur == E3OH_IDX_NR) begin
        rx_nr_q <= rx_byte;
      end
      if (rx_idx_cur == E3OH_IDX_GC) begin
        rx_gc_q <= rx_byte;
      end
      if (rx_idx_cur == E3OH_IDX_MA) begin
        rx_ma_q <= rx_byte;
      end
    end
  end

  // Receive LAPD octet out of the selected carrier byte
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      lapd_rx_byte  <= E3OH_RST_BYTE;
      lapd_rx_valid <= 1'b0;
    end else begin
      lapd_rx_valid <= 1'b0;
      if (rx_byte_en && ctrl_q.lapd_en &&
          (rx_idx_cur == (ctrl_q.lapd_gc ? E3OH_IDX_GC : E3OH_IDX_NR))) begin
        lapd_rx_byte  <= rx_byte;
        lapd_rx_valid <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ctrl_q  <= E3OH_RST_CTRL;
      tx_nr_q <= E3OH_RST_BYTE;
      tx_gc_q <= E3OH_RST_BYTE;
    end else if (reg_wr) begin
      case (reg_addr)
        E3OH_ADDR_TX_NR: tx_nr_q <= reg_wdata;
        E3OH_ADDR_TX_GC: tx_gc_q <= reg_wdata;
        E3OH_ADDR_CTRL:  ctrl_q  <= reg_wdata;
        default:         ctrl_q  <= ctrl_q;
      endcase
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdata_d = E3OH_RST_BYTE;
    case (reg_addr)
      E3OH_ADDR_RX_NR:  rdata_d = rx_nr_q;
      E3OH_ADDR_RX_GC:  rdata_d = rx_gc_q;
      E3OH_ADDR_TX_GC:  rdata_d = tx_gc_q;
      E3OH_ADDR_TX_NR:  rdata_d = tx_nr_q;
      E3OH_ADDR_CTRL:   rdata_d = ctrl_q;
      E3OH_ADDR_STATUS: rdata_d = {4'h0, rx_bip_ok_q, febe_pend_q,
                                   rx_problem, pay_ready};
      E3OH_ADDR_RX_MA:  rdata_d = rx_ma_q;
      default:          rdata_d = E3OH_RST_BYTE;
    endcase
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      reg_rdata <= E3OH_RST_BYTE;
    end else begin
      reg_rdata <= reg_rd ? rdata_d : E3OH_RST_BYTE;
    end
  end

endmodule : e3oh_overhead

// >>> e3oh_overhead_sva.sv
// Checker for the E3 overhead byte block
`timescale 1ns/1ps
module e3oh_overhead_sva
  import e3oh_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       tx_byte_en,
  input wire logic [7:0] tx_byte,
  input wire logic       tx_byte_valid,
  input wire logic       tx_frame_end,
  input wire logic [7:0] lapd_tx_byte,
  input wire logic       lapd_tx_take,
  input wire logic       rx_los,
  input wire logic       rx_oof,
  input wire logic       rx_ais
);
  logic [9:0] idx_q;
  logic [7:0] nr_q, gc_q, ctrl_q;
  logic       ma_slot;
  logic       rx_bad;
  logic [5:0] ma_low;
  // Slot index rebuilt from the slot strobes
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      idx_q <= E3OH_RST_IDX;
    end else if (tx_byte_en) begin
      idx_q <= (idx_q == E3OH_LAST_IDX) ? E3OH_RST_IDX : idx_q + 10'h001;
    end
  end
  // Shadows of the writable registers, seen only through bus writes
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      nr_q <= E3OH_RST_BYTE;
      gc_q <= E3OH_RST_BYTE;
      ctrl_q <= E3OH_RST_CTRL;
    end else if (reg_wr) begin
      if (reg_addr == E3OH_ADDR_TX_NR) nr_q <= reg_wdata;
      if (reg_addr == E3OH_ADDR_TX_GC) gc_q <= reg_wdata;
      if (reg_addr == E3OH_ADDR_CTRL) ctrl_q <= reg_wdata;
    end
  end
  // Slot decodes
  assign ma_slot = tx_byte_en && (idx_q == E3OH_IDX_MA);
  assign rx_bad = rx_los || rx_oof || rx_ais;
  assign ma_low = {ctrl_q[4:2], E3OH_PDEP_VAL, ctrl_q[5]};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_ferf_set: assert property (ma_slot && rx_bad |=> tx_byte[7])
    else $error("alarm bit not set in outbound byte");
  a_ferf_clear: assert property (ma_slot && !rx_bad |=> !tx_byte[7])
    else $error("alarm bit set without receive problem");
  a_ma_fields: assert property (ma_slot |=> tx_byte[5:0] == $past(ma_low))
    else $error("type, dependent or marker field wrong");
  a_nr_fill: assert property (tx_byte_en && idx_q == E3OH_IDX_NR &&
    !(ctrl_q[0] && !ctrl_q[1]) |=> tx_byte == $past(nr_q))
    else $error("operator byte differs from register");
  a_gc_fill: assert property (tx_byte_en && idx_q == E3OH_IDX_GC &&
    !(ctrl_q[0] && ctrl_q[1]) |=> tx_byte == $past(gc_q))
    else $error("general byte differs from register");
  a_lapd_slot: assert property (tx_byte_en && ctrl_q[0] && idx_q ==
    (ctrl_q[1] ? E3OH_IDX_GC : E3OH_IDX_NR) |=> lapd_tx_take && tx_byte == $past(lapd_tx_byte))
    else $error("link octet not carried");
  a_frame_mark: assert property (tx_byte_en |=> tx_byte_valid && tx_frame_end ==
    ($past(idx_q) == E3OH_LAST_IDX))
    else $error("byte strobe or frame end misplaced");
  a_no_slot: assert property (!tx_byte_en |=> !tx_byte_valid && !lapd_tx_take && !tx_frame_end)
    else $error("outbound strobe without slot");
  a_rd_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read cycle");
endmodule : e3oh_overhead_sva

bind e3oh_overhead e3oh_overhead_sva u_sva (.clk_sys(clk_sys), .rst_b(rst_b),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .tx_byte_en(tx_byte_en), .tx_byte(tx_byte),
  .tx_byte_valid(tx_byte_valid), .tx_frame_end(tx_frame_end), .lapd_tx_byte(lapd_tx_byte),
  .lapd_tx_take(lapd_tx_take), .rx_los(rx_los), .rx_oof(rx_oof), .rx_ais(rx_ais));

// >>> e3oh_remote.sv
// Remote terminal model: sends inbound frames, watches outbound alarms
`timescale 1ns/1ps
module e3oh_remote
  import e3oh_pkg::*;
#(
  parameter int unsigned FERF_FRAMES = 3
) (
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic [7:0] nr_val,
  input  wire logic [7:0] gc_val,
  input  wire logic       em_corrupt,
  output logic            rx_byte_en,
  output logic            rx_frame_start,
  output logic [7:0]      rx_byte,
  output logic            em_bad,
  input  wire logic [7:0] tx_byte,
  input  wire logic       tx_byte_valid,
  input  wire logic       tx_frame_end,
  output logic            far_fail
);
  logic [9:0] idx_q;
  logic [9:0] tidx_q;
  logic [7:0] acc_q;
  logic [7:0] bip_q;
  int         ferf_cnt;
  // Inbound frame source, one byte every cycle, parity of last frame in EM
  always @(posedge clk_sys) begin : rx_gen
    logic [7:0] b;
    if (!rst_b) begin
      idx_q <= E3OH_RST_IDX;
      acc_q <= 8'h00;
      bip_q <= 8'h00;
      rx_byte_en <= 1'b0;
      rx_frame_start <= 1'b0;
      rx_byte <= 8'h00;
      em_bad <= 1'b0;
    end else begin
      case (idx_q)
        E3OH_IDX_FA1: b = E3OH_FA1_VAL;
        E3OH_IDX_FA2: b = E3OH_FA2_VAL;
        E3OH_IDX_EM: b = bip_q ^ {7'h00, em_corrupt};
        E3OH_IDX_MA: b = {2'h0, E3OH_PT_ATM, E3OH_PDEP_VAL, 1'b1};
        E3OH_IDX_NR: b = nr_val;
        E3OH_IDX_GC: b = gc_val;
        default: b = 8'($urandom);
      endcase
      rx_byte_en <= 1'b1;
      rx_frame_start <= (idx_q == E3OH_RST_IDX);
      rx_byte <= b;
      em_bad <= (idx_q == E3OH_IDX_EM) && em_corrupt;
      acc_q <= (idx_q == E3OH_RST_IDX) ? b : acc_q ^ b;
      if (idx_q == E3OH_LAST_IDX) begin
        bip_q <= acc_q ^ b;
        idx_q <= E3OH_RST_IDX;
      end else begin
        idx_q <= idx_q + 10'h001;
      end
    end
  end
  // Alarm filter: failure declared after consecutive frames with the bit set
  always @(posedge clk_sys) begin
    if (!rst_b) begin
      tidx_q <= E3OH_RST_IDX;
      ferf_cnt <= 0;
      far_fail <= 1'b0;
    end else if (tx_byte_valid) begin
      tidx_q <= tx_frame_end ? E3OH_RST_IDX : tidx_q + 10'h001;
      if (tidx_q == E3OH_IDX_MA) begin
        ferf_cnt <= tx_byte[7] ? ferf_cnt + 1 : 0;
        far_fail <= tx_byte[7] && (ferf_cnt + 1 >= FERF_FRAMES);
      end
    end
  end
endmodule : e3oh_remote

// >>> testbench.sv
// Self-checking bench for the E3 overhead byte block
`timescale 1ns/1ps
module testbench;
  import e3oh_pkg::*;
  logic       clk_sys, rst_b, reg_wr, reg_rd, pay_valid, pay_ready, tx_byte_en, tx_byte_valid;
  logic       tx_frame_end, lapd_tx_take, rx_byte_en, rx_frame_start, rx_los, rx_oof, rx_ais;
  logic       lapd_rx_valid, rx_bip_err, em_corrupt, em_bad, far_fail, exp_v, bip_exp, m_febe;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, pay_data, tx_trail_byte, tx_byte, lapd_tx_byte;
  logic [7:0] rx_byte, lapd_rx_byte, nr_val, gc_val, m_nr, m_gc, m_ctrl, m_acc, m_bip, exp_q;
  logic [9:0] m_idx;
  logic [7:0] payq[$];
  int         n_fail, comparisons, cyc;
  e3oh_overhead u_dut (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pay_valid(pay_valid), .pay_ready(pay_ready), .pay_data(pay_data), .tx_byte_en(tx_byte_en),
    .tx_trail_byte(tx_trail_byte), .tx_byte(tx_byte), .tx_byte_valid(tx_byte_valid),
    .tx_frame_end(tx_frame_end), .lapd_tx_byte(lapd_tx_byte), .lapd_tx_take(lapd_tx_take),
    .rx_byte_en(rx_byte_en), .rx_frame_start(rx_frame_start), .rx_byte(rx_byte),
    .rx_los(rx_los), .rx_oof(rx_oof), .rx_ais(rx_ais), .lapd_rx_byte(lapd_rx_byte),
    .lapd_rx_valid(lapd_rx_valid), .rx_bip_err(rx_bip_err));
  e3oh_remote u_far (.clk_sys(clk_sys), .rst_b(rst_b), .nr_val(nr_val), .gc_val(gc_val),
    .em_corrupt(em_corrupt), .rx_byte_en(rx_byte_en), .rx_frame_start(rx_frame_start),
    .rx_byte(rx_byte), .em_bad(em_bad), .tx_byte(tx_byte), .tx_byte_valid(tx_byte_valid),
    .tx_frame_end(tx_frame_end), .far_fail(far_fail));
  ////////////////
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    if (a == E3OH_ADDR_TX_NR) m_nr <= d;
    if (a == E3OH_ADDR_TX_GC) m_gc <= d;
    if (a == E3OH_ADDR_CTRL) m_ctrl <= d;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    check(reg_rdata, e);
  endtask : rd
  task automatic wait_frames(input int n);
    repeat (n) begin
      tx_trail_byte <= 8'($urandom);
      repeat (537) @(posedge clk_sys);
    end
  endtask : wait_frames
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : final_report
  ////////////////
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // Hang guard, well above the roughly 20000 cycles the tests need
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_fail++;
      final_report();
    end
  end
  // Reference model of every outbound byte and of the parity error pulse
  always @(posedge clk_sys) begin : tx_model
    logic [7:0] e;
    if (!rst_b) begin
      m_idx <= E3OH_RST_IDX;
      m_acc <= 8'h00;
      m_bip <= 8'h00;
      m_febe <= 1'b0;
      exp_v <= 1'b0;
      bip_exp <= 1'b0;
    end else begin
      if (exp_v) check(tx_byte, exp_q);
      if (bip_exp || rx_bip_err) check({7'h00, rx_bip_err}, {7'h00, bip_exp});
      bip_exp <= rx_byte_en && em_bad;
      exp_v <= tx_byte_en;
      if (rx_byte_en && em_bad) m_febe <= 1'b1;
      if (tx_byte_en) begin
        case (m_idx)
          E3OH_IDX_FA1: e = E3OH_FA1_VAL;
          E3OH_IDX_FA2: e = E3OH_FA2_VAL;
          E3OH_IDX_EM: e = m_bip;
          E3OH_IDX_TR: e = tx_trail_byte;
          E3OH_IDX_MA: e = {rx_los | rx_oof | rx_ais, m_febe, m_ctrl[4:2], 2'h0, m_ctrl[5]};
          E3OH_IDX_NR: e = (m_ctrl[1:0] == 2'h1) ? lapd_tx_byte : m_nr;
          E3OH_IDX_GC: e = (m_ctrl[1:0] == 2'h3) ? lapd_tx_byte : m_gc;
          default: e = (payq.size() > 0) ? payq.pop_front() : 8'h00;
        endcase
        if (m_idx == E3OH_IDX_MA && !(rx_byte_en && em_bad)) m_febe <= 1'b0;
        exp_q <= e;
        m_acc <= (m_idx == E3OH_RST_IDX) ? e : m_acc ^ e;
        if (m_idx == E3OH_LAST_IDX) begin
          m_bip <= m_acc ^ e;
          m_idx <= E3OH_RST_IDX;
        end else begin
          m_idx <= m_idx + 10'h001;
        end
      end
    end
  end
  ////////////////
  initial begin : main
    logic [7:0] v;
    int k;
    {rst_b, reg_wr, reg_rd, pay_valid, tx_byte_en, rx_los, rx_oof, rx_ais, em_corrupt} = '0;
    {reg_addr, reg_wdata, pay_data, tx_trail_byte, lapd_tx_byte} = '0;
    {m_nr, m_gc, m_ctrl} = '0;
    cyc = 0;
    v = 8'($urandom(32'h0103));
    nr_val = 8'($urandom);
    gc_val = 8'($urandom);
    repeat (8) @(posedge clk_sys);
    rst_b <= 1'b1;
    tx_byte_en <= 1'b1;
    // Registers: transmit NR reset value, read back, unmapped place
    rd(E3OH_ADDR_TX_NR, 8'h00);
    for (k = 0; k < 2; k++) begin
      v = 8'($urandom);
      wr(k[0] ? E3OH_ADDR_TX_GC : E3OH_ADDR_TX_NR, v);
      rd(k[0] ? E3OH_ADDR_TX_GC : E3OH_ADDR_TX_NR, v);
    end
    wr(8'h55, 8'hff);
    rd(8'h55, 8'h00);
    $display("test registers done");
    // Every payload type code with both marker values
    for (k = 0; k < 8; k++) begin
      wr(E3OH_ADDR_CTRL, {2'h0, k[2], 1'b0, k[1:0], 2'h0});
      wait_frames(1);
    end
    $display("test payload type done");
    // Each receive problem raises the alarm until it clears
    for (k = 0; k < 3; k++) begin
      {rx_ais, rx_oof, rx_los} <= 3'h1 << k;
      wait_frames(4);
      check({7'h00, far_fail}, 8'h01);
      {rx_ais, rx_oof, rx_los} <= 3'h0;
      wait_frames(2);
      check({7'h00, far_fail}, 8'h00);
    end
    $display("test alarm done");
    // One corrupted parity byte gives one block error report
    em_corrupt <= 1'b1;
    for (k = 0; k < 600 && !em_bad; k++) @(posedge clk_sys);
    em_corrupt <= 1'b0;
    wait_frames(2);
    $display("test block error done");
    // Receive capture, read-only write ignored, then link octets in both bytes
    wait_frames(1);
    wr(E3OH_ADDR_RX_NR, ~nr_val);
    rd(E3OH_ADDR_RX_NR, nr_val);
    rd(E3OH_ADDR_RX_GC, gc_val);
    rd(E3OH_ADDR_RX_MA, {2'h0, E3OH_PT_ATM, E3OH_PDEP_VAL, 1'b1});
    rd(E3OH_ADDR_STATUS, 8'h09);
    for (k = 0; k < 2; k++) begin
      lapd_tx_byte <= 8'($urandom);
      wr(E3OH_ADDR_CTRL, {6'h00, k[0], 1'b1});
      repeat (2) @(posedge clk_sys);
      while (!lapd_rx_valid) @(posedge clk_sys);
      check(lapd_rx_byte, k[0] ? gc_val : nr_val);
      wait_frames(1);
    end
    wr(E3OH_ADDR_CTRL, 8'h00);
    $display("test operator bytes done");
    // Fill the buffer with the outbound side stalled, then drain it
    tx_byte_en <= 1'b0;
    pay_valid <= 1'b1;
    pay_data <= 8'($urandom);
    for (k = 0; k < 40; k++) begin
      @(posedge clk_sys);
      if (pay_ready) begin
        payq.push_back(pay_data);
        pay_data <= 8'($urandom);
      end
    end
    pay_valid <= 1'b0;
    check(8'(payq.size()), 8'h20);
    check({7'h00, pay_ready}, 8'h00);
    tx_byte_en <= 1'b1;
    wait_frames(1);
    check(8'(payq.size()), 8'h00);
    $display("test buffer done");
    final_report();
  end
endmodule : testbench
